// >>> common/nrf_consts.vh
// register offsets, field positions and reset values of the node request filter bank
`ifndef NRF_CONSTS_VH
`define NRF_CONSTS_VH

`define NRF_OFS_ASYNC_HI_SET   12'h100
`define NRF_OFS_ASYNC_HI_CLR   12'h104
`define NRF_OFS_ASYNC_LO_SET   12'h108
`define NRF_OFS_ASYNC_LO_CLR   12'h10C
`define NRF_OFS_PHYS_HI_SET    12'h110
`define NRF_OFS_PHYS_HI_CLR    12'h114
`define NRF_OFS_LAST_DECISION  12'h180
`define NRF_OFS_REJECT_COUNT   12'h184

`define NRF_MASK_RESET         32'h00000000
`define NRF_PHYS_KEEP_MASK     32'h80000000
`define NRF_NONE_KEEP_MASK     32'h00000000
`define NRF_REMOTE_BIT         31
`define NRF_LOCAL_BUS_ALIAS    10'h3FF
`define NRF_BROADCAST_NODE     6'h3F
`define NRF_READ_ZERO          32'h00000000

`define NRF_DEC_ACCEPT_BIT     0
`define NRF_DEC_PHYS_BIT       1
`define NRF_DEC_REMOTE_BIT     2
`define NRF_DEC_ASYNC_BIT      3
`define NRF_DEC_NODE_LSB       8

`endif

// >>> src/nrf_mask_reg.v
// one read/set/clear node mask register with selective survival of the phy-initiated reset
module nrf_mask_reg #(
  parameter WIDTH                 = 32,
  parameter [WIDTH-1:0] KEEP_MASK = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             phyReset,
  input  wire             setStrobe,
  input  wire             clrStrobe,
  input  wire [WIDTH-1:0] writeData,
  output wire [WIDTH-1:0] maskValue
);

  reg [WIDTH-1:0] mask_reg;
  reg [WIDTH-1:0] mask_next;

  // ones set or clear, zeros leave the bit alone; the bus write is applied after
  // the phy reset so software issued in the same cycle is not lost
  always @* begin
    mask_next = mask_reg;
    if (phyReset) begin
      mask_next = mask_reg & KEEP_MASK;
    end
    if (setStrobe) begin
      mask_next = mask_next | writeData;
    end else if (clrStrobe) begin
      mask_next = mask_next & ~writeData;
    end
  end

  // power-on reset clears every bit, including the ones kept through phy reset
  always @(posedge clk) begin
    if (!reset_n) begin
      mask_reg <= {WIDTH{1'b0}};
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign maskValue = mask_reg;

endmodule // nrf_mask_reg

// >>> src/nrf_filter_bank.v
// node request filter bank: apb set/clear masks and per-request accept and routing decision
`include "nrf_consts.vh"

module nrf_filter_bank #(
  parameter ADDR_WIDTH  = 12,
  parameter COUNT_WIDTH = 16
) (
  input  wire                  clk,
  input  wire                  reset_n,
  // apb slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [ADDR_WIDTH-1:0] paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // bus identity of this controller and phy-initiated reset pulse
  input  wire [9:0]            localBusId,
  input  wire                  phy_initiated_reset,
  // incoming request from the receive path
  input  wire                  reqValid,
  input  wire [9:0]            reqSrcBus,
  input  wire [5:0]            reqSrcNode,
  input  wire                  reqPhysical,
  // decision, one cycle after the request
  output reg                   decValid,
  output reg                   decAck,
  output reg                   decToPhys,
  output reg                   decToAsyncContext
);

  wire [31:0] asyncHiMask;
  wire [31:0] asyncLoMask;
  wire [31:0] physHiMask;

  reg  [31:0]            lastDecision_reg;
  reg  [31:0]            lastDecision_next;
  reg  [COUNT_WIDTH-1:0] rejectCount_reg;
  reg  [COUNT_WIDTH-1:0] rejectCount_next;

  // picks node n out of a 64-bit mask, shared by the async and physical lookups
  function nodeBit;
    input [63:0] mask;
    input [5:0]  node;
    begin
      nodeBit = mask[node];
    end
  endfunction

  // ---------------- apb decode ----------------
  wire setupPhase  = psel & ~penable;
  wire accessDone  = psel & penable & pready;
  wire writeDone   = accessDone & pwrite;

  wire hitAsyncHiSet = (paddr == `NRF_OFS_ASYNC_HI_SET);
  wire hitAsyncHiClr = (paddr == `NRF_OFS_ASYNC_HI_CLR);
  wire hitAsyncLoSet = (paddr == `NRF_OFS_ASYNC_LO_SET);
  wire hitAsyncLoClr = (paddr == `NRF_OFS_ASYNC_LO_CLR);
  wire hitPhysHiSet  = (paddr == `NRF_OFS_PHYS_HI_SET);
  wire hitPhysHiClr  = (paddr == `NRF_OFS_PHYS_HI_CLR);
  wire hitLastDec    = (paddr == `NRF_OFS_LAST_DECISION);
  wire hitRejectCnt  = (paddr == `NRF_OFS_REJECT_COUNT);

  // the address is checked for word alignment too; a misaligned access is unmapped
  wire aligned = (paddr[1:0] == 2'b00);

  reg [31:0] readValue;
  reg        mapped;

  // read mux: either offset of a filter returns its current mask
  always @* begin
    readValue = `NRF_READ_ZERO;
    mapped    = 1'b1;
    if (hitAsyncHiSet || hitAsyncHiClr) begin
      readValue = asyncHiMask;
    end else if (hitAsyncLoSet || hitAsyncLoClr) begin
      readValue = asyncLoMask;
    end else if (hitPhysHiSet || hitPhysHiClr) begin
      readValue = physHiMask;
    end else if (hitLastDec) begin
      readValue = lastDecision_reg;
    end else if (hitRejectCnt) begin
      readValue = {{(32-COUNT_WIDTH){1'b0}}, rejectCount_reg};
    end else begin
      mapped = 1'b0;
    end
    if (!aligned) begin
      readValue = `NRF_READ_ZERO;
      mapped    = 1'b0;
    end
  end

  // one wait-free access: answer is loaded during setup and stands for one access cycle
  always @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= `NRF_READ_ZERO;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? `NRF_READ_ZERO : readValue;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      prdata  <= `NRF_READ_ZERO;
      pslverr <= 1'b0;
    end
  end

  // write strobes fire only at the completing edge of the access phase
  wire wrAsyncHiSet = writeDone & aligned & hitAsyncHiSet;
  wire wrAsyncHiClr = writeDone & aligned & hitAsyncHiClr;
  wire wrAsyncLoSet = writeDone & aligned & hitAsyncLoSet;
  wire wrAsyncLoClr = writeDone & aligned & hitAsyncLoClr;
  wire wrPhysHiSet  = writeDone & aligned & hitPhysHiSet;
  wire wrPhysHiClr  = writeDone & aligned & hitPhysHiClr;

  // ---------------- filter masks ----------------
  // upper async filter: nodes 62..32 in bits 30..0, bit 31 is never consulted
  nrf_mask_reg #(
    .WIDTH     (32),
    .KEEP_MASK (`NRF_NONE_KEEP_MASK)
  ) u_async_hi (
    .clk       (clk),
    .reset_n   (reset_n),
    .phyReset  (phy_initiated_reset),
    .setStrobe (wrAsyncHiSet),
    .clrStrobe (wrAsyncHiClr),
    .writeData (pwdata),
    .maskValue (asyncHiMask)
  );

  // lower async filter: identical register, nodes 31..0
  nrf_mask_reg #(
    .WIDTH     (32),
    .KEEP_MASK (`NRF_NONE_KEEP_MASK)
  ) u_async_lo (
    .clk       (clk),
    .reset_n   (reset_n),
    .phyReset  (phy_initiated_reset),
    .setStrobe (wrAsyncLoSet),
    .clrStrobe (wrAsyncLoClr),
    .writeData (pwdata),
    .maskValue (asyncLoMask)
  );

  // upper physical filter; only the remote-bus bit is kept through a phy reset
  nrf_mask_reg #(
    .WIDTH     (32),
    .KEEP_MASK (`NRF_PHYS_KEEP_MASK)
  ) u_phys_hi (
    .clk       (clk),
    .reset_n   (reset_n),
    .phyReset  (phy_initiated_reset),
    .setStrobe (wrPhysHiSet),
    .clrStrobe (wrPhysHiClr),
    .writeData (pwdata),
    .maskValue (physHiMask)
  );

  // ---------------- request decision ----------------
  // the broadcast node id has no filter bit, so bit 63 of each vector is never consulted
  wire [63:0] asyncVector = {1'b0, asyncHiMask[30:0], asyncLoMask};
  // no lower physical filter here: accepted local requests from nodes 0..31 always go to the async context
  wire [63:0] physVector  = {1'b0, physHiMask[30:0], 32'h00000000};

  wire srcLocal     = (reqSrcBus == localBusId) || (reqSrcBus == `NRF_LOCAL_BUS_ALIAS);
  wire srcBroadcast = (reqSrcNode == `NRF_BROADCAST_NODE);
  wire remoteOk     = physHiMask[`NRF_REMOTE_BIT];

  reg  accept;
  reg  toPhys;

  // local sources are compared node by node; remote sources only see the all-buses bit
  always @* begin
    accept = 1'b0;
    toPhys = 1'b0;
    if (srcLocal) begin
      accept = ~srcBroadcast & nodeBit(asyncVector, reqSrcNode);
      toPhys = accept & reqPhysical & nodeBit(physVector, reqSrcNode);
    end else begin
      accept = remoteOk;
      toPhys = accept & reqPhysical;
    end
  end

  // outputs are registered so the receive path sees a clean one-cycle pulse
  always @(posedge clk) begin
    if (!reset_n) begin
      decValid          <= 1'b0;
      decAck            <= 1'b0;
      decToPhys         <= 1'b0;
      decToAsyncContext <= 1'b0;
    end else if (reqValid) begin
      decValid          <= 1'b1;
      decAck            <= accept;
      decToPhys         <= toPhys;
      decToAsyncContext <= accept & ~toPhys;
    end else begin
      decValid          <= 1'b0;
      decAck            <= 1'b0;
      decToPhys         <= 1'b0;
      decToAsyncContext <= 1'b0;
    end
  end

  // ---------------- observation registers ----------------
  // last decision snapshot and a saturating reject count for software diagnosis
  always @* begin
    lastDecision_next = lastDecision_reg;
    rejectCount_next  = rejectCount_reg;
    if (reqValid) begin
      lastDecision_next = `NRF_READ_ZERO;
      lastDecision_next[`NRF_DEC_ACCEPT_BIT] = accept;
      lastDecision_next[`NRF_DEC_PHYS_BIT]   = toPhys;
      lastDecision_next[`NRF_DEC_REMOTE_BIT] = ~srcLocal;
      lastDecision_next[`NRF_DEC_ASYNC_BIT]  = accept & ~toPhys;
      lastDecision_next[`NRF_DEC_NODE_LSB +: 6] = reqSrcNode;
      if (!accept && (rejectCount_reg != {COUNT_WIDTH{1'b1}})) begin
        rejectCount_next = rejectCount_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // a write of any value to the reject count offset zeroes it; a reject in the
  // same cycle wins so that no event is lost
  always @(posedge clk) begin
    if (!reset_n) begin
      lastDecision_reg <= `NRF_READ_ZERO;
      rejectCount_reg  <= {COUNT_WIDTH{1'b0}};
    end else begin
      lastDecision_reg <= lastDecision_next;
      if (writeDone && aligned && hitRejectCnt && !(reqValid && !accept)) begin
        rejectCount_reg <= {COUNT_WIDTH{1'b0}};
      end else begin
        rejectCount_reg <= rejectCount_next;
      end
    end
  end

endmodule // nrf_filter_bank

// >>> verif/nrf_filter_bank_asserts.sv
// port checker for the node request filter bank
`include "nrf_consts.vh"
module nrf_fb_asserts #(parameter ADDR_WIDTH = 12) (
  input logic                  clk,
  input logic                  reset_n,
  input logic                  psel,
  input logic                  penable,
  input logic                  pwrite,
  input logic [ADDR_WIDTH-1:0] paddr,
  input logic [31:0]           pwdata,
  input logic                  pready,
  input logic [9:0]            localBusId,
  input logic                  reqValid,
  input logic [9:0]            reqSrcBus,
  input logic [5:0]            reqSrcNode,
  input logic                  reqPhysical,
  input logic                  decValid,
  input logic                  decAck,
  input logic                  decToPhys,
  input logic                  decToAsyncContext
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic remoteOk_reg;
  logic isLocal;
  logic wrDone;
  assign isLocal = reqSrcBus == localBusId || reqSrcBus == 10'h3FF;
  assign wrDone  = psel && penable && pready && pwrite && pwdata[31];
  // shadow of the all-buses bit; the phy reset deliberately leaves it alone
  always @(posedge clk) begin
    if (!reset_n) remoteOk_reg <= 1'b0;
    else if (wrDone && paddr == `NRF_OFS_PHYS_HI_SET) remoteOk_reg <= 1'b1;
    else if (wrDone && paddr == `NRF_OFS_PHYS_HI_CLR) remoteOk_reg <= 1'b0;
  end
  property p_dec_follow; reqValid |=> decValid; endproperty
  property p_dec_cause; decValid |-> $past(reqValid); endproperty
  property p_route; decValid |-> decAck == (decToPhys | decToAsyncContext) && !(decToPhys && decToAsyncContext);
  endproperty
  property p_low_phys; reqValid && (!reqPhysical || isLocal && !reqSrcNode[5]) |=> !decToPhys; endproperty
  property p_bcast; reqValid && isLocal && reqSrcNode == 6'h3F |=> !decAck; endproperty
  property p_remote;
    reqValid && !isLocal |=> decAck == $past(remoteOk_reg) && decToPhys == (decAck && $past(reqPhysical));
  endproperty
  property p_rdy; psel && !penable |=> pready; endproperty
  property p_rdy_one; pready |=> !pready; endproperty
  a_dec_follow: assert property (p_dec_follow) else $error("no decision after request");
  a_dec_cause: assert property (p_dec_cause) else $error("decision without request");
  a_route: assert property (p_route) else $error("route flags inconsistent");
  a_low_phys: assert property (p_low_phys) else $error("unexpected physical route");
  a_bcast: assert property (p_bcast) else $error("broadcast source accepted");
  a_remote: assert property (p_remote) else $error("remote bus decision wrong");
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
  c_remote: cover property (reqValid && !isLocal ##1 decAck);
  c_phys: cover property (decToPhys);
  c_async: cover property (decToAsyncContext);
endmodule // nrf_fb_asserts

bind nrf_filter_bank nrf_fb_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .localBusId(localBusId),
  .reqValid(reqValid), .reqSrcBus(reqSrcBus), .reqSrcNode(reqSrcNode), .reqPhysical(reqPhysical),
  .decValid(decValid), .decAck(decAck), .decToPhys(decToPhys), .decToAsyncContext(decToAsyncContext));

// >>> verif/nrf_remote_node.sv
// model of the remote nodes that deliver request packets
module nrf_remote_node (
  input  logic       clk,
  output logic       reqValid,
  output logic [9:0] reqSrcBus,
  output logic [5:0] reqSrcNode,
  output logic       reqPhysical
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reqValid = 1'b0;
    reqSrcBus = 10'h000;
    reqSrcNode = 6'h00;
    reqPhysical = 1'b0;
  end
  // one-cycle packet; fields flip afterwards so stale values cannot pass for fresh ones
  task automatic send(input logic [9:0] b, input logic [5:0] n, input logic p);
    @(posedge clk);
    reqValid <= 1'b1;
    reqSrcBus <= b;
    reqSrcNode <= n;
    reqPhysical <= p;
    @(posedge clk);
    reqValid <= 1'b0;
    reqSrcBus <= ~b;
    reqSrcNode <= ~n;
    reqPhysical <= ~p;
  endtask
endmodule // nrf_remote_node

// >>> verif/nrf_filter_bank_test.sv
// self-checking bench for the node request filter bank
`include "nrf_consts.vh"
module nrf_filter_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, phyRst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ah, al, ph;
  logic [9:0]  localBusId, reqSrcBus;
  logic [5:0]  reqSrcNode;
  logic        reqValid, reqPhysical, decValid, decAck, decToPhys, decToAsyncContext;
  logic [32:0] rdQ[$];
  logic [2:0]  decQ[$];
  logic [11:0] offs[7] = '{12'h100, 12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118};
  int          failures, nChecks, rejects;
  logic [31:0] lastDec;
  nrf_filter_bank dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .localBusId(localBusId), .phy_initiated_reset(phyRst), .reqValid(reqValid), .reqSrcBus(reqSrcBus),
    .reqSrcNode(reqSrcNode), .reqPhysical(reqPhysical), .decValid(decValid), .decAck(decAck),
    .decToPhys(decToPhys), .decToAsyncContext(decToAsyncContext));
  nrf_remote_node peer_u (.clk(clk), .reqValid(reqValid), .reqSrcBus(reqSrcBus), .reqSrcNode(reqSrcNode),
    .reqPhysical(reqPhysical));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [32:0] g, input logic [32:0] e);
    nChecks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // apb transfer; the model is updated up front since transfers never overlap
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rdQ.push_back(a == `NRF_OFS_LAST_DECISION ? {1'b0, lastDec} : a == `NRF_OFS_REJECT_COUNT ?
      {17'h00000, rejects[15:0]} : a[11:3] == 9'h020 ? {1'b0, ah} : a[11:3] == 9'h021 ? {1'b0, al}
      : a[11:3] == 9'h022 ? {1'b0, ph} : {1'b1, 32'h00000000});
    else case (a)
      `NRF_OFS_ASYNC_HI_SET: ah = ah | d;
      `NRF_OFS_ASYNC_HI_CLR: ah = ah & ~d;
      `NRF_OFS_ASYNC_LO_SET: al = al | d;
      `NRF_OFS_ASYNC_LO_CLR: al = al & ~d;
      `NRF_OFS_PHYS_HI_SET: ph = ph | d;
      `NRF_OFS_PHYS_HI_CLR: ph = ph & ~d;
      `NRF_OFS_REJECT_COUNT: rejects = 0;
      default: ;
    endcase
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected decision: local sources filtered per node, remote ones by the all-buses bit
  task automatic req(input logic [9:0] b, input logic [5:0] n, input logic p);
    logic loc, acc, toP;
    loc = b == localBusId || b == 10'h3FF;
    acc = loc ? n != 6'h3F && (n[5] ? ah[n[4:0]] : al[n[4:0]]) : ph[31];
    toP = acc && p && (loc ? n[5] && ph[n[4:0]] : 1'b1);
    decQ.push_back({acc, toP, acc && !toP});
    if (!acc) rejects++;
    lastDec = {18'h00000, n, 4'h0, acc && !toP, !loc, toP, acc};
    peer_u.send(b, n, p);
  endtask
  // result watcher: each answer is paired with the oldest expectation
  always @(posedge clk) begin
    if (pready === 1'b1 && !pwrite) check({pslverr, prdata}, rdQ.pop_front());
    if (decValid !== 1'b0) check({30'h0, decAck, decToPhys, decToAsyncContext}, {30'h0, decQ.pop_front()});
  end
  initial begin
    #400000;
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h0560C3D1));
    {reset_n, psel, penable, pwrite, phyRst} = 5'h00;
    {paddr, pwdata, ah, al, ph, lastDec} = '0;
    rejects = 0;
    localBusId = 10'h000;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    localBusId <= 10'($urandom % 1000);
    foreach (offs[i]) apb(offs[i], 1'b0, 32'h00000000);
    for (int r = 0; r < 4; r++) begin
      repeat (8) apb(offs[$urandom % 7], 1'b1, $urandom);
      apb(r[0] ? `NRF_OFS_PHYS_HI_SET : `NRF_OFS_PHYS_HI_CLR, 1'b1, 32'h80000000);
      if (r == 3) begin
        @(posedge clk);
        phyRst <= 1'b1;
        @(posedge clk);
        phyRst <= 1'b0;
        {ah, al} = '0;
        ph = ph & 32'h80000000;
      end
      foreach (offs[i]) apb(offs[i], 1'b0, 32'h00000000);
      for (int n = 0; n < 64; n++) req(n[0] ? localBusId : 10'h3FF, n[5:0], 1'($urandom));
      repeat (4) req(localBusId + 10'h001, 6'($urandom), 1'($urandom));
      // diagnosis registers: last decision, rejects of this round, then a clearing write
      apb(`NRF_OFS_LAST_DECISION, 1'b0, 32'h00000000);
      apb(`NRF_OFS_REJECT_COUNT, 1'b0, 32'h00000000);
      apb(`NRF_OFS_REJECT_COUNT, 1'b1, $urandom);
    end
    repeat (4) @(posedge clk);
    // every noted expectation must have met its answer
    check(33'(rdQ.size() + decQ.size()), 33'h000000000);
    complete_run();
  end
endmodule // nrf_filter_bank_test
